// ---- rtl/icu_pkg.sv ----
// Package of constants for the input capture unit.
package icu_pkg;

  // ==========================================================================
  // Register map.
  localparam logic [1:0] ADDR_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_BUFFER = 2'h1;
  localparam logic [1:0] ADDR_IRQ_STATUS = 2'h2;
  localparam logic [1:0] ADDR_IRQ_MASK = 2'h3;

  // ==========================================================================
  // Control register fields.
  localparam int IDLE_STOP_POS = 13;
  localparam int TIMER_SEL_POS = 7;
  localparam int PER_IRQ_LSB = 5;
  localparam int OVERFLOW_POS = 4;
  localparam int NOT_EMPTY_POS = 3;
  localparam int MODE_LSB = 0;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] CONTROL_WMASK = 16'h20E7;

  // ==========================================================================
  // Interrupt status bits.
  localparam int EV_CAPTURE_IRQ = 0;
  localparam int EV_OVERFLOW = 1;
  localparam int EV_WAKE = 2;
  localparam int EV_COUNT = 3;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // ==========================================================================
  // Mode codes and buffer sizing.
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_EVERY_EDGE = 3'h1;
  localparam logic [2:0] MODE_FALL = 3'h2;
  localparam logic [2:0] MODE_RISE = 3'h3;
  localparam logic [2:0] MODE_RISE4 = 3'h4;
  localparam logic [2:0] MODE_RISE16 = 3'h5;
  localparam logic [2:0] MODE_UNUSED = 3'h6;
  localparam logic [2:0] MODE_WAKE = 3'h7;
  localparam int FIFO_DEPTH = 4;
  localparam logic [3:0] PRESCALE_4 = 4'h3;
  localparam logic [3:0] PRESCALE_16 = 4'hF;

endpackage

// ---- rtl/icu_capture.sv ----
// Input capture unit with control register, capture buffer and interrupt.
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
// ============================================================================
// Notes on behaviour
// [RL1] Idle-stop bit set halts capture while the CPU idles; clear keeps it running.
// [RL2] Timer-select set stores second timer count, clear stores third timer.
// [RL3] Captures-per-irq codes 00..11 interrupt on every 1st..4th capture.
// [RL4] Read-only overflow flag reads one after a capture overflow.
// [RL5] Read-only buffer flag reads one while a captured value remains.
// [RL6] Mode 111 is only a rising-edge wake interrupt in sleep or idle.
// [RL7] Mode 110 is unused and behaves as disabled.
// [RL8] Mode 101 captures every 16th rising edge, 100 every 4th.
// [RL9] Mode 011 captures every rising edge, 010 every falling edge.
// [RL10] Mode 001 captures both edges; interrupt on every capture there.
// [RL11] Mode 000 turns the unit off with no edge detection.
// [RL12] Status flags ignore software writes; they clear when the buffer drains or when mode 000 is written.
// [RL13] Captures sit in a four-entry FIFO; each read pops the oldest.
// [RL14] Capture into a full buffer sets overflow and keeps stored entries.
// [RL15] Reset clears all writable control fields to zero.
module icu_capture (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [1:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic cap_pin_i,
  input wire logic cpu_idle_i,
  input wire logic cpu_sleep_i,
  input wire logic [15:0] second_timer_count_i,
  input wire logic [15:0] third_timer_count_i,
  output logic irq_o
);

  typedef struct packed {
    logic [1:0] pin_sync;
    logic pin_prev;
    logic [2:0] mode;
    logic idle_stop_bit;
    logic timer_select_bit;
    logic [1:0] captures_per_irq;
    logic overflow_flag;
    logic [3:0] prescale;
    logic [1:0] irq_count;
    logic [15:0] fifo0;
    logic [15:0] fifo1;
    logic [15:0] fifo2;
    logic [15:0] fifo3;
    logic [1:0] rd_ptr;
    logic [1:0] wr_ptr;
    logic [2:0] level;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [15:0] rdata;
    logic irq;
  } icu_state_s;

  icu_state_s state_q;
  icu_state_s state_d;
  logic [15:0] entry [icu_pkg::FIFO_DEPTH];
  logic [15:0] control_view;
  logic rise;
  logic fall;
  logic halted;
  logic edge_hit;
  logic capture;
  logic pop;
  logic push;
  logic [2:0] events;

  assign entry[0] = state_q.fifo0;
  assign entry[1] = state_q.fifo1;
  assign entry[2] = state_q.fifo2;
  assign entry[3] = state_q.fifo3;

  // ==========================================================================
  // Control register as software sees it; flags are derived from state.
  always_comb begin
    control_view = 16'h0000;
    control_view[icu_pkg::IDLE_STOP_POS] = state_q.idle_stop_bit;
    control_view[icu_pkg::TIMER_SEL_POS] = state_q.timer_select_bit;
    control_view[icu_pkg::PER_IRQ_LSB +: 2] = state_q.captures_per_irq;
    control_view[icu_pkg::OVERFLOW_POS] = state_q.overflow_flag; // RL4
    control_view[icu_pkg::NOT_EMPTY_POS] = state_q.level != 3'h0; // RL5
    control_view[icu_pkg::MODE_LSB +: 3] = state_q.mode;
  end

  // ==========================================================================
  // Edge detection and capture decision.
  always_comb begin
    rise = state_q.pin_sync[1] & ~state_q.pin_prev;
    fall = ~state_q.pin_sync[1] & state_q.pin_prev;
    halted = state_q.idle_stop_bit & cpu_idle_i; // RL1
    edge_hit = 1'b0;
    case (state_q.mode)
      icu_pkg::MODE_EVERY_EDGE: edge_hit = rise | fall; // RL10
      icu_pkg::MODE_FALL: edge_hit = fall; // RL9
      icu_pkg::MODE_RISE: edge_hit = rise; // RL9
      icu_pkg::MODE_RISE4: edge_hit = rise &&
        state_q.prescale[1:0] == icu_pkg::PRESCALE_4[1:0]; // RL8
      icu_pkg::MODE_RISE16: edge_hit = rise &&
        state_q.prescale == icu_pkg::PRESCALE_16; // RL8
      default: edge_hit = 1'b0; // RL7 RL11
    endcase
    capture = edge_hit & ~halted;
    pop = rd_i && addr_i == icu_pkg::ADDR_BUFFER && state_q.level != 3'h0;
    push = capture && state_q.level != 3'(icu_pkg::FIFO_DEPTH); // RL14
    events = 3'h0;
    if (capture) begin
      // Every-edge mode ignores the per-interrupt count.
      if (state_q.mode == icu_pkg::MODE_EVERY_EDGE ||
          state_q.irq_count == state_q.captures_per_irq) begin // RL3 RL10
        events[icu_pkg::EV_CAPTURE_IRQ] = 1'b1;
      end
    end
    events[icu_pkg::EV_OVERFLOW] = capture & ~push; // RL14
    events[icu_pkg::EV_WAKE] = state_q.mode == icu_pkg::MODE_WAKE &&
      (cpu_sleep_i || cpu_idle_i) && rise; // RL6
  end

  // ==========================================================================
  // Next state.
  always_comb begin
    state_d = state_q;
    state_d.pin_sync = {state_q.pin_sync[0], cap_pin_i};
    state_d.pin_prev = state_q.pin_sync[1];
    // The divider counts every unhalted rising edge of a divided mode, not only the
    // ones that capture, otherwise it would never reach its terminal count.
    if (rise && !halted && (state_q.mode == icu_pkg::MODE_RISE4 ||
        state_q.mode == icu_pkg::MODE_RISE16)) begin
      state_d.prescale = state_q.prescale + 4'h1; // RL8
    end
    if (capture) begin
      if (state_q.mode == icu_pkg::MODE_EVERY_EDGE ||
          state_q.irq_count == state_q.captures_per_irq) begin
        state_d.irq_count = 2'h0;
      end else begin
        state_d.irq_count = state_q.irq_count + 2'h1;
      end
    end
    if (push) begin
      // Timer value is taken in the capture cycle itself.
      case (state_q.wr_ptr)
        2'h0: state_d.fifo0 = state_q.timer_select_bit ?
          second_timer_count_i : third_timer_count_i; // RL2 RL13
        2'h1: state_d.fifo1 = state_q.timer_select_bit ?
          second_timer_count_i : third_timer_count_i;
        2'h2: state_d.fifo2 = state_q.timer_select_bit ?
          second_timer_count_i : third_timer_count_i;
        default: state_d.fifo3 = state_q.timer_select_bit ?
          second_timer_count_i : third_timer_count_i;
      endcase
      state_d.wr_ptr = state_q.wr_ptr + 2'h1;
    end
    if (pop) begin
      state_d.rd_ptr = state_q.rd_ptr + 2'h1; // RL13
    end
    state_d.level = state_q.level + {2'h0, push} - {2'h0, pop};
    if (events[icu_pkg::EV_OVERFLOW]) begin
      state_d.overflow_flag = 1'b1; // RL14
    end else if (pop && !push && state_q.level == 3'h1) begin
      state_d.overflow_flag = 1'b0; // RL12
    end
    state_d.rdata = 16'h0000;
    if (rd_i) begin
      if (addr_i == icu_pkg::ADDR_CONTROL) begin
        state_d.rdata = control_view;
      end else if (addr_i == icu_pkg::ADDR_BUFFER) begin
        state_d.rdata = state_q.level != 3'h0 ? entry[state_q.rd_ptr] :
          16'h0000;
      end else if (addr_i == icu_pkg::ADDR_IRQ_STATUS) begin
        state_d.rdata = {13'h0000, state_q.irq_status};
      end else begin
        state_d.rdata = {13'h0000, state_q.irq_mask};
      end
    end
    state_d.irq_status = state_q.irq_status;
    if (wr_i) begin
      if (addr_i == icu_pkg::ADDR_CONTROL) begin
        // Flag bits are not in the write mask and so ignore writes.
        state_d.idle_stop_bit = wdata_i[icu_pkg::IDLE_STOP_POS]; // RL12
        state_d.timer_select_bit = wdata_i[icu_pkg::TIMER_SEL_POS];
        state_d.captures_per_irq = wdata_i[icu_pkg::PER_IRQ_LSB +: 2];
        state_d.mode = wdata_i[icu_pkg::MODE_LSB +: 3];
        if (wdata_i[icu_pkg::MODE_LSB +: 3] == icu_pkg::MODE_OFF) begin
          // Turning off drains the buffer and clears both flags.
          state_d.level = 3'h0; // RL11 RL12
          state_d.rd_ptr = 2'h0;
          state_d.wr_ptr = 2'h0;
          state_d.overflow_flag = 1'b0;
          state_d.prescale = 4'h0;
          state_d.irq_count = 2'h0;
        end
      end else if (addr_i == icu_pkg::ADDR_IRQ_STATUS) begin
        state_d.irq_status = state_q.irq_status & ~wdata_i[2:0];
      end else if (addr_i == icu_pkg::ADDR_IRQ_MASK) begin
        state_d.irq_mask = wdata_i[2:0];
      end
    end
    // Hardware set beats a software clear in the same cycle.
    state_d.irq_status = state_d.irq_status | events;
    state_d.irq = |(state_d.irq_status & state_d.irq_mask);
  end

  // ==========================================================================
  // State register.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= '0; // RL15
    end else begin
      state_q <= state_d;
    end
  end

  assign rdata_o = state_q.rdata;
  assign irq_o = state_q.irq;

endmodule // icu_capture

// ---- verification/icu_capture_asserts.sv ----
// Port assertions for the capture unit.
`timescale 1ns/100ps
module icu_capture_asserts (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [1:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic cap_pin_i,
  input wire logic cpu_idle_i,
  input wire logic cpu_sleep_i,
  input wire logic irq_o
);
  // ==========================================================================
  // Shadows of the writable registers, so checks know the programmed mode.
  logic [15:0] ctl_q;
  logic [2:0] msk_q;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctl_q <= 16'h0000;
      msk_q <= 3'h0;
    end else if (wr_i && addr_i == icu_pkg::ADDR_CONTROL) begin
      ctl_q <= wdata_i & icu_pkg::CONTROL_WMASK;
    end else if (wr_i && addr_i == icu_pkg::ADDR_IRQ_MASK) begin
      msk_q <= wdata_i[2:0];
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_ctl_rd;
    rd_i && addr_i == icu_pkg::ADDR_CONTROL;
  endsequence
  sequence s_pin_up;
    $rose(cap_pin_i);
  endsequence
  // ==========================================================================
  // Checks.
  chk_rd_quiet: assert property (!rd_i |=> rdata_o == 16'h0000)
    else $error("read data not zero outside a read");
  chk_ctl_readback: assert property (s_ctl_rd |=>
    (rdata_o & icu_pkg::CONTROL_WMASK) == $past(ctl_q))
    else $error("control readback differs from written value");
  chk_ovf_needs_data: assert property (s_ctl_rd |=>
    !rdata_o[4] || rdata_o[3]) else $error("overflow set with empty buffer");
  chk_off_flushes: assert property ((s_ctl_rd and
    (ctl_q[2:0] == 3'h0)) |=> rdata_o[4:3] == 2'h0)
    else $error("status flags set while off");
  chk_irq_masked: assert property (irq_o |-> |msk_q)
    else $error("interrupt high with all sources masked");
  chk_rise_irq: assert property (s_pin_up and (ctl_q[2:0] == 3'h3 &&
    ctl_q[6:5] == 2'h0 && &msk_q[1:0] && !cpu_idle_i) |-> ##[1:6] irq_o)
    else $error("rising edge gave no interrupt");
  chk_wake_irq: assert property (s_pin_up and (ctl_q[2:0] == 3'h7 &&
    msk_q[2] && cpu_sleep_i) |-> ##[1:6] irq_o)
    else $error("wake edge gave no interrupt");
  chk_status_width: assert property (rd_i && addr_i == 2'h2 |=>
    rdata_o[15:3] == 13'h0000) else $error("status reads unused bits");
endmodule // icu_capture_asserts

bind icu_capture icu_capture_asserts u_chk (.*);

// ---- verification/icu_pin_model.sv ----
// Signal source that drives the capture pin.
`timescale 1ns/100ps
module icu_pin_model (
  input wire logic clk_i,
  output logic pin_o
);
  initial pin_o = 1'b0;
  // Levels are held several clocks so the synchroniser cannot miss one.
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk_i);
      pin_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      pin_o <= 1'b0;
      repeat (5) @(posedge clk_i);
    end
  endtask
endmodule // icu_pin_model

// ---- verification/input_capture_unit_tb_top.sv ----
// Self-checking bench for the capture unit.
`timescale 1ns/100ps
module input_capture_unit_tb_top;
  localparam logic [1:0] A_CTL = icu_pkg::ADDR_CONTROL;
  localparam logic [1:0] A_BUF = icu_pkg::ADDR_BUFFER;
  localparam logic [1:0] A_STS = icu_pkg::ADDR_IRQ_STATUS;
  localparam logic [1:0] A_MSK = icu_pkg::ADDR_IRQ_MASK;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [1:0] addr_i = 2'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic idle = 1'b0;
  logic sleep = 1'b0;
  logic [15:0] t2 = 16'hA5A5;
  logic [15:0] t3 = 16'h3C3C;
  logic [15:0] rdata_o;
  logic [15:0] v;
  logic pin;
  logic irq_o;
  int err_total = 0;
  int cmp_count = 0;
  int n;
  initial forever #10 ref_clk_i = ~ref_clk_i;
  icu_capture u_icu_capture (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .cap_pin_i(pin), .cpu_idle_i(idle),
    .cpu_sleep_i(sleep), .second_timer_count_i(t2),
    .third_timer_count_i(t3), .irq_o(irq_o));
  icu_pin_model u_icu_pin_model (.clk_i(ref_clk_i), .pin_o(pin));
  // ==========================================================================
  // Bus and compare helpers.
  task automatic chk(input string s, input logic [15:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", s, exp, got);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  // Writing mode off first flushes buffer and prescaler between cases.
  task automatic setup(input logic [15:0] c, input logic [15:0] m);
    wr(A_CTL, 16'h0000);
    wr(A_STS, 16'h0007);
    wr(A_MSK, m);
    wr(A_CTL, c);
  endtask
  task automatic count();
    n = 0;
    rd(A_CTL);
    while (v[3] === 1'b1 && n < 8) begin
      rd(A_BUF);
      n++;
      rd(A_CTL);
    end
  endtask
  // ==========================================================================
  // Scenarios.
  task automatic t_reset();
    rd(A_CTL);
    chk("ctl", v, 16'h0000);
    rd(A_BUF);
    chk("empty", v, 16'h0000);
  endtask
  task automatic t_tsel();
    setup(16'h0003, 16'h0000);
    u_icu_pin_model.pulse(1);
    rd(A_BUF);
    chk("third", v, t3);
    t2 <= 16'h5AC3;
    wr(A_CTL, 16'h0083);
    u_icu_pin_model.pulse(1);
    rd(A_BUF);
    chk("second", v, t2);
  endtask
  task automatic t_ovf();
    setup(16'h001B, 16'h0003);
    rd(A_CTL);
    chk("ro", v, 16'h0003);
    for (int i = 0; i < 5; i++) begin
      t3 <= 16'h1000 + 16'(i);
      u_icu_pin_model.pulse(1);
    end
    rd(A_CTL);
    chk("ovf", v, 16'h001B);
    rd(A_STS);
    chk("sts", v, 16'h0003);
    for (int i = 0; i < 4; i++) begin
      rd(A_BUF);
      chk("fifo", v, 16'h1000 + 16'(i));
    end
    rd(A_CTL);
    chk("drained", v, 16'h0003);
  endtask
  task automatic t_modes();
    logic [2:0] md[9] = '{3'h0, 3'h6, 3'h7, 3'h4, 3'h4,
      3'h5, 3'h5, 3'h2, 3'h1};
    int k[9] = '{4, 4, 4, 3, 4, 15, 16, 1, 1};
    int e[9] = '{0, 0, 0, 0, 1, 0, 1, 1, 2};
    for (int i = 0; i < 9; i++) begin
      setup({13'h0000, md[i]}, 16'h0000);
      u_icu_pin_model.pulse(k[i]);
      count();
      chk("mode", 16'(n), 16'(e[i]));
    end
  endtask
  task automatic t_irq();
    for (int c = 0; c < 4; c++) begin
      setup(16'h0003 | 16'(c << 5), 16'h0001);
      u_icu_pin_model.pulse(c);
      chk("early", {15'h0000, irq_o}, 16'h0000);
      u_icu_pin_model.pulse(1);
      chk("irq", {15'h0000, irq_o}, 16'h0001);
    end
    setup(16'h0061, 16'h0001);
    u_icu_pin_model.pulse(1);
    chk("edge", {15'h0000, irq_o}, 16'h0001);
    wr(A_STS, 16'h0001);
    wr(A_MSK, 16'h0001);
    chk("clr", {15'h0000, irq_o}, 16'h0000);
    rd(A_MSK);
    chk("msk", v, 16'h0001);
  endtask
  task automatic t_idle();
    idle <= 1'b1;
    setup(16'h2003, 16'h0000);
    u_icu_pin_model.pulse(1);
    count();
    chk("halt", 16'(n), 16'h0000);
    setup(16'h0003, 16'h0000);
    u_icu_pin_model.pulse(1);
    count();
    chk("run", 16'(n), 16'h0001);
    idle <= 1'b0;
    sleep <= 1'b1;
    setup(16'h0007, 16'h0004);
    u_icu_pin_model.pulse(1);
    chk("wake", {15'h0000, irq_o}, 16'h0001);
    rd(A_STS);
    chk("wsts", v, 16'h0004);
    sleep <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    t_reset();
    t_tsel();
    t_ovf();
    t_modes();
    t_irq();
    t_idle();
    tally_and_finish();
  end
  initial begin
    #1000000;
    err_total++;
    tally_and_finish();
  end
endmodule // input_capture_unit_tb_top
